// ==== dif_pkg.sv ====
// Constants, function codes and carrier structs for the digital input function selector.
// Assumes one 200 MHz control clock and an APB master with 32-bit data.
package dif_pkg;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned FILT_TIME_NS  = 1000;
    // Least filter time, rounded up to whole cycles
    localparam int unsigned FILT_CYC      = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          FILT_W        = 8;
    localparam int          N_IN          = 4;
    localparam int          FSEL_W        = 4;
    localparam int          OL_W          = 16;
    localparam int          IRQ_W         = 4;
    localparam int          ADDR_W        = 8;

    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FSEL     = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_OL_SAVED = 8'h18;

    localparam int CTRL_VCLASS_LSB = 0;
    localparam int CTRL_OLRET_BIT  = 4;
    localparam int STS_IN_LSB      = 0;
    localparam int STS_FLAG_LSB    = 4;

    localparam logic [1:0]                  VCLASS_LOW  = 2'h2;
    localparam logic [1:0]                  VCLASS_HIGH = 2'h3;
    localparam logic [1:0]                  RST_VCLASS  = VCLASS_HIGH;
    localparam logic                        RST_OLRET   = 1'h0;
    localparam logic [N_IN*FSEL_W-1:0]      RST_FSEL    = 16'hb544;
    localparam logic [IRQ_W-1:0]            RST_IRQ_EN  = 4'h0;

    localparam int IRQ_AUX      = 0;
    localparam int IRQ_FCLR     = 1;
    localparam int IRQ_OLRST    = 2;
    localparam int IRQ_CONFLICT = 3;

    typedef enum logic [FSEL_W-1:0] {
        FN_NONE       = 4'h0,
        FN_ALT_RAMP   = 4'h1,
        FN_JOG        = 4'h2,
        FN_AUX_FAULT  = 4'h3,
        FN_PRESET     = 4'h4,
        FN_LOCAL      = 4'h5,
        FN_COMM       = 4'h6,
        FN_CLR_FAULT  = 4'h7,
        FN_STOP_RAMP  = 4'h8,
        FN_STOP_COAST = 4'h9,
        FN_STOP_DCINJ = 4'ha,
        FN_JOG_FWD    = 4'hb,
        FN_JOG_REV    = 4'hc
    } dif_func_e;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } dif_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } dif_apb_rsp_s;

    typedef struct packed {
        logic       alt_ramp;
        logic       jog;
        logic       jog_rev;
        logic       preset_act;
        logic [2:0] preset_sel;
        logic       local_ctrl;
        logic       comm_ctrl;
        logic       stop_ramp;
        logic       stop_coast;
        logic       stop_dcinj;
        logic       aux_fault;
        logic       fault_clr;
        logic       volt_high;
    } dif_cmd_s;

    typedef struct packed {
        logic                         ol_reset;
        logic                         ol_restore;
        logic [OL_W-1:0]              ol_value;
    } dif_ol_s;

    typedef struct packed {
        logic [N_IN-1:0]              sync1;
        logic [N_IN-1:0]              sync2;
        logic [N_IN-1:0]              filt;
        logic [N_IN-1:0]              filt_d;
        logic [N_IN-1:0][FILT_W-1:0]  fcnt;
        logic [1:0]                   vclass;
        logic                         ol_ret;
        logic [N_IN-1:0][FSEL_W-1:0]  fsel;
        logic [IRQ_W-1:0]             irq_stat;
        logic [IRQ_W-1:0]             irq_en;
        logic                         irq;
        logic                         conflict;
        logic                         pg_s1;
        logic                         pg_s2;
        logic                         pg_d;
        logic [OL_W-1:0]              ol_saved;
        dif_ol_s                      ol;
        dif_apb_rsp_s                 rsp;
        dif_cmd_s                     cmd;
    } dif_state_s;
endpackage : dif_pkg

// ==== dif_top.sv ====
// Digital input function selector: four filtered terminals mapped to drive commands, APB registers.
// Assumes APB master on i_mclk, motor core on i_mclk, terminals and power-good asynchronous.
`timescale 1ns/1ps
module dif_top #(
    parameter logic [dif_pkg::FILT_W-1:0] FILT_CYCLES = dif_pkg::FILT_W'(dif_pkg::FILT_CYC)
) (
    input  wire logic                        i_mclk,
    input  wire logic                        i_arst_n,
    input  wire dif_pkg::dif_apb_req_s       i_apb,
    output      dif_pkg::dif_apb_rsp_s       o_apb,
    input  wire logic [dif_pkg::N_IN-1:0]    i_din,
    input  wire logic                        i_start_valid,
    input  wire logic                        i_power_good,
    input  wire logic [dif_pkg::OL_W-1:0]    i_ol_count,
    output      dif_pkg::dif_cmd_s           o_cmd,
    output      dif_pkg::dif_ol_s            o_ol,
    output      logic [dif_pkg::N_IN-1:0]    o_input_status,
    output      logic                        o_irq
);
    dif_pkg::dif_state_s st_reg;
    dif_pkg::dif_state_s st_next;

    logic [15:0]                 f_act;
    logic [15:0]                 f_rise;
    logic [dif_pkg::IRQ_W-1:0]   irq_ev;
    logic [dif_pkg::IRQ_W-1:0]   irq_clr;
    logic                        seen_alt;
    logic                        seen_comm;
    logic                        conflict;
    logic [1:0]                  rank;
    logic [2:0]                  psel_bits;
    logic                        any_preset;
    logic                        setup;
    logic                        wr;
    logic                        hit;
    logic [31:0]                 rdata;
    logic                        clr_fault;
    logic                        set_aux;
    logic                        jog_fwd;
    logic                        jog_rev;

    always_comb
    begin
        st_next    = st_reg;
        f_act      = '0;
        f_rise     = '0;
        irq_ev     = '0;
        irq_clr    = '0;
        seen_alt   = 1'b0;
        seen_comm  = 1'b0;
        conflict   = 1'b0;
        rank       = 2'h0;
        psel_bits  = 3'h0;
        any_preset = 1'b0;
        hit        = 1'b0;
        rdata      = '0;

        // Two-stage synchroniser, then a stability counter per terminal
        st_next.sync1  = i_din;
        st_next.sync2  = st_reg.sync1;
        st_next.filt_d = st_reg.filt;
        for (int i = 0; i < dif_pkg::N_IN; i++)
        begin
            if (st_reg.sync2[i] == st_reg.filt[i])
            begin
                st_next.fcnt[i] = '0;
            end
            else if (st_reg.fcnt[i] == FILT_CYCLES - 8'h01)
            begin
                st_next.filt[i] = st_reg.sync2[i];
                st_next.fcnt[i] = '0;
            end
            else
            begin
                st_next.fcnt[i] = st_reg.fcnt[i] + 8'h01;
            end
        end

        // Function decode; duplicated exclusive functions honour the lowest input only
        for (int i = 0; i < dif_pkg::N_IN; i++)
        begin
            if (st_reg.fsel[i] == dif_pkg::FN_ALT_RAMP)
            begin
                if (!seen_alt)
                begin
                    f_act[dif_pkg::FN_ALT_RAMP] = st_reg.filt[i];
                end
                else
                begin
                    conflict = 1'b1;
                end
                seen_alt = 1'b1;
            end
            else if (st_reg.fsel[i] == dif_pkg::FN_COMM)
            begin
                if (!seen_comm)
                begin
                    f_act[dif_pkg::FN_COMM] = st_reg.filt[i];
                end
                else
                begin
                    conflict = 1'b1;
                end
                seen_comm = 1'b1;
            end
            else if (st_reg.fsel[i] == dif_pkg::FN_PRESET)
            begin
                // Preset select bits taken in terminal order
                if (rank != 2'h3)
                begin
                    psel_bits[rank] = st_reg.filt[i];
                    rank            = rank + 2'h1;
                end
                any_preset = any_preset | st_reg.filt[i];
            end
            else
            begin
                // Function 0 and unsupported codes drive nothing here
                f_act[st_reg.fsel[i]]  = f_act[st_reg.fsel[i]] | st_reg.filt[i];
                f_rise[st_reg.fsel[i]] = f_rise[st_reg.fsel[i]] | (st_reg.filt[i] & ~st_reg.filt_d[i]);
            end
        end

        // Faults are cleared on the edge, so a held input does not mask new faults
        clr_fault = f_rise[dif_pkg::FN_CLR_FAULT]
                  | f_rise[dif_pkg::FN_STOP_RAMP]
                  | f_rise[dif_pkg::FN_STOP_COAST]
                  | f_rise[dif_pkg::FN_STOP_DCINJ];
        // Removed input is a low level; fault re-asserts while it stays low
        set_aux   = 1'b0;
        for (int i = 0; i < dif_pkg::N_IN; i++)
        begin
            if (st_reg.fsel[i] == dif_pkg::FN_AUX_FAULT && !st_reg.filt[i])
            begin
                set_aux = 1'b1;
            end
        end
        jog_fwd = f_act[dif_pkg::FN_JOG] | f_act[dif_pkg::FN_JOG_FWD];
        jog_rev = f_act[dif_pkg::FN_JOG_REV];

        st_next.cmd.alt_ramp   = f_act[dif_pkg::FN_ALT_RAMP];
        // Both directions at once is ambiguous, so neither jogs
        st_next.cmd.jog        = (jog_fwd ^ jog_rev) & ~i_start_valid;
        st_next.cmd.jog_rev    = jog_rev & ~jog_fwd & ~i_start_valid;
        st_next.cmd.preset_act = any_preset;
        st_next.cmd.preset_sel = psel_bits;
        st_next.cmd.local_ctrl = f_act[dif_pkg::FN_LOCAL];
        st_next.cmd.comm_ctrl  = f_act[dif_pkg::FN_COMM];
        st_next.cmd.stop_ramp  = f_act[dif_pkg::FN_STOP_RAMP];
        st_next.cmd.stop_coast = f_act[dif_pkg::FN_STOP_COAST];
        st_next.cmd.stop_dcinj = f_act[dif_pkg::FN_STOP_DCINJ];
        st_next.cmd.fault_clr  = clr_fault;
        // Set wins over clear
        st_next.cmd.aux_fault  = set_aux | (st_reg.cmd.aux_fault & ~clr_fault);
        st_next.cmd.volt_high  = (st_reg.vclass == dif_pkg::VCLASS_HIGH);
        st_next.conflict       = conflict;

        // APB: registered answer, no wait states
        setup = i_apb.psel & ~i_apb.penable;
        wr    = i_apb.psel & i_apb.penable & st_reg.rsp.pready & i_apb.pwrite;
        unique case (i_apb.paddr)
            dif_pkg::OFS_CTRL:
            begin
                hit   = 1'b1;
                rdata = {27'h0, st_reg.ol_ret, 2'h0, st_reg.vclass};
            end
            dif_pkg::OFS_FSEL:
            begin
                hit   = 1'b1;
                rdata = {16'h0, st_reg.fsel};
            end
            dif_pkg::OFS_STATUS:
            begin
                hit   = 1'b1;
                rdata = {17'h0, st_reg.cmd.preset_act, st_reg.cmd.preset_sel, st_reg.conflict,
                         st_reg.cmd.comm_ctrl, st_reg.cmd.local_ctrl, st_reg.cmd.jog_rev, st_reg.cmd.jog,
                         st_reg.cmd.alt_ramp, st_reg.cmd.aux_fault, st_reg.filt};
            end
            dif_pkg::OFS_IRQ_STAT:
            begin
                hit   = 1'b1;
                rdata = {28'h0, st_reg.irq_stat};
            end
            dif_pkg::OFS_IRQ_CLR:
            begin
                hit   = 1'b1;
            end
            dif_pkg::OFS_IRQ_EN:
            begin
                hit   = 1'b1;
                rdata = {28'h0, st_reg.irq_en};
            end
            dif_pkg::OFS_OL_SAVED:
            begin
                hit   = 1'b1;
                rdata = {16'h0, st_reg.ol_saved};
            end
            default:
            begin
                hit   = 1'b0;
            end
        endcase
        st_next.rsp.pready  = setup;
        st_next.rsp.pslverr = setup & ~hit;
        st_next.rsp.prdata  = (setup & ~i_apb.pwrite) ? rdata : 32'h0;

        st_next.ol.ol_reset   = 1'b0;
        st_next.ol.ol_restore = 1'b0;
        if (wr)
        begin
            unique case (i_apb.paddr)
                dif_pkg::OFS_CTRL:
                begin
                    // Codes other than the two classes are ignored
                    if (i_apb.pwdata[dif_pkg::CTRL_VCLASS_LSB+:2] == dif_pkg::VCLASS_LOW ||
                        i_apb.pwdata[dif_pkg::CTRL_VCLASS_LSB+:2] == dif_pkg::VCLASS_HIGH)
                    begin
                        st_next.vclass = i_apb.pwdata[dif_pkg::CTRL_VCLASS_LSB+:2];
                    end
                    st_next.ol_ret = i_apb.pwdata[dif_pkg::CTRL_OLRET_BIT];
                    if (i_apb.pwdata[dif_pkg::CTRL_OLRET_BIT] != st_reg.ol_ret)
                    begin
                        st_next.ol.ol_reset = 1'b1;
                    end
                end
                dif_pkg::OFS_FSEL:
                begin
                    st_next.fsel = i_apb.pwdata[dif_pkg::N_IN*dif_pkg::FSEL_W-1:0];
                end
                dif_pkg::OFS_IRQ_CLR:
                begin
                    irq_clr = i_apb.pwdata[dif_pkg::IRQ_W-1:0];
                end
                dif_pkg::OFS_IRQ_EN:
                begin
                    st_next.irq_en = i_apb.pwdata[dif_pkg::IRQ_W-1:0];
                end
                default:
                begin
                    st_next.ol.ol_reset = 1'b0;
                end
            endcase
        end

        // Power-good edges drive overload retention
        st_next.pg_s1 = i_power_good;
        st_next.pg_s2 = st_reg.pg_s1;
        st_next.pg_d  = st_reg.pg_s2;
        if (st_reg.ol.ol_reset)
        begin
            st_next.ol_saved = '0;
        end
        else if (st_reg.ol_ret && st_reg.pg_d && !st_reg.pg_s2)
        begin
            st_next.ol_saved = i_ol_count;
        end
        if (st_reg.ol_ret && !st_reg.pg_d && st_reg.pg_s2)
        begin
            st_next.ol.ol_restore = 1'b1;
        end
        st_next.ol.ol_value = st_reg.ol_saved;

        irq_ev[dif_pkg::IRQ_AUX]      = set_aux & ~st_reg.cmd.aux_fault;
        irq_ev[dif_pkg::IRQ_FCLR]     = clr_fault;
        irq_ev[dif_pkg::IRQ_OLRST]    = st_reg.ol.ol_reset;
        irq_ev[dif_pkg::IRQ_CONFLICT] = conflict & ~st_reg.conflict;
        st_next.irq_stat = (st_reg.irq_stat & ~irq_clr) | irq_ev;
        st_next.irq      = |(st_next.irq_stat & st_next.irq_en);
    end

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st_reg        <= '0;
            st_reg.vclass <= dif_pkg::RST_VCLASS;
            st_reg.ol_ret <= dif_pkg::RST_OLRET;
            st_reg.fsel   <= dif_pkg::RST_FSEL;
            st_reg.irq_en <= dif_pkg::RST_IRQ_EN;
            st_reg.cmd.volt_high <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_apb          = st_reg.rsp;
    assign o_cmd          = st_reg.cmd;
    assign o_ol           = st_reg.ol;
    assign o_input_status = st_reg.filt;
    assign o_irq          = st_reg.irq;

    sequence s_ctrl_write;
        i_apb.psel && i_apb.penable && st_reg.rsp.pready && i_apb.pwrite && i_apb.paddr == dif_pkg::OFS_CTRL;
    endsequence

    sequence s_ret_toggle;
        s_ctrl_write ##0 (i_apb.pwdata[dif_pkg::CTRL_OLRET_BIT] != st_reg.ol_ret);
    endsequence

    AST_VCLASS_LEGAL: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        st_reg.vclass == dif_pkg::VCLASS_LOW || st_reg.vclass == dif_pkg::VCLASS_HIGH)
        else $error("voltage class left legal codes");

    AST_OLRST_ON_CHANGE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        s_ret_toggle |=> o_ol.ol_reset ##1 (st_reg.ol_saved == '0))
        else $error("retention change did not reset counter");

    AST_RESTORE_NEEDS_RET: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        $rose(o_ol.ol_restore) |-> st_reg.ol_ret && $past(st_reg.pg_s2) && !$past(st_reg.pg_d))
        else $error("restore without enabled retention on power-up");

    AST_JOG_OVERRIDE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_start_valid |=> !o_cmd.jog && !o_cmd.jog_rev)
        else $error("jog not overridden by start");

    AST_STOP_RAMP: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        f_act[dif_pkg::FN_STOP_RAMP] |=> o_cmd.stop_ramp)
        else $error("ramp stop not forced");

    AST_STOP_COAST: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        f_act[dif_pkg::FN_STOP_COAST] |=> o_cmd.stop_coast)
        else $error("coast stop not forced");

    AST_STOP_DCINJ: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        f_act[dif_pkg::FN_STOP_DCINJ] |=> o_cmd.stop_dcinj)
        else $error("dc injection stop not forced");

    AST_FAULT_CLR_PULSE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        o_cmd.fault_clr |=> !o_cmd.fault_clr)
        else $error("fault clear longer than one cycle");

    AST_AUX_FELL: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        $fell(o_cmd.aux_fault) |-> o_cmd.fault_clr)
        else $error("aux fault dropped without clear");

    AST_FILTER_HOLD: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        $changed(st_reg.filt[0]) |-> $past(st_reg.fcnt[0]) == FILT_CYCLES - 8'h01)
        else $error("filtered input changed before filter time");

    AST_IRQ_LEVEL: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        o_irq == |(st_reg.irq_stat & st_reg.irq_en))
        else $error("interrupt level mismatch");

    AST_PREADY_ONE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        o_apb.pready |=> !o_apb.pready)
        else $error("pready held beyond one cycle");
endmodule : dif_top

// ==== dif_core_model.sv ====
// Motor core stand-in: holds the overload counter that the selector saves and restores.
// Assumes the selector's i_mclk domain and its registered dif_ol_s pulses.
`timescale 1ns/1ps
module dif_core_model (
    input  wire logic                     i_mclk,
    input  wire logic                     i_arst_n,
    input  wire logic                     i_run,
    input  wire dif_pkg::dif_ol_s         i_ol,
    output      logic [dif_pkg::OL_W-1:0] o_count
);
    // Counter rises only while running, so a stopped motor gives a steady value
    always_ff @(posedge i_mclk or negedge i_arst_n)
        if (!i_arst_n)
            o_count <= '0;
        else if (i_ol.ol_reset)
            o_count <= '0;
        else if (i_ol.ol_restore)
            o_count <= i_ol.ol_value;
        else if (i_run)
            o_count <= o_count + 16'h0001;
endmodule : dif_core_model

// ==== tb_top.sv ====
// Self-checking bench for the input function selector with random terminal levels.
// Assumes the core model beside it and an APB master made of the tasks below.
`timescale 1ns/1ps
module tb_top;
    logic                  mclk = 1'b0;
    logic                  arst_n = 1'b0;
    dif_pkg::dif_apb_req_s apb_req = '0;
    dif_pkg::dif_apb_rsp_s apb_rsp;
    logic [3:0]            din = 4'h0;
    logic                  start_valid = 1'b0;
    logic                  power_good = 1'b1;
    logic                  run = 1'b1;
    logic [15:0]           ol_count;
    dif_pkg::dif_cmd_s     cmd;
    dif_pkg::dif_ol_s      ol;
    logic [3:0]            in_sts;
    logic                  irq;
    int                    n_fail = 0;
    int                    checked = 0;
    int                    n_clr = 0;
    always #2.5 mclk = ~mclk;
    // Counts fault clear pulses, which last one cycle and would slip past a late look
    always @(posedge mclk) n_clr <= n_clr + int'(cmd.fault_clr);
    // Short filter keeps each settle wait small
    dif_top #(.FILT_CYCLES(8'h04)) dut (.i_mclk(mclk), .i_arst_n(arst_n), .i_apb(apb_req), .o_apb(apb_rsp),
        .i_din(din), .i_start_valid(start_valid), .i_power_good(power_good), .i_ol_count(ol_count),
        .o_cmd(cmd), .o_ol(ol), .o_input_status(in_sts), .o_irq(irq));
    dif_core_model m (.i_mclk(mclk), .i_arst_n(arst_n), .i_run(run), .i_ol(ol), .o_count(ol_count));
    task automatic report_and_stop();
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x)
        begin
            n_fail++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        // Answer taken at the rising edge that sees pready, request released only then
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (apb_rsp.pready !== 1'b1 && n < 20);
        r = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '0;
        if (apb_rsp.pready !== 1'b1)
        begin
            n_fail++;
            report_and_stop();
        end
    endtask : apb
    task automatic apply(input logic [3:0] d, input logic s);
        din <= d;
        start_valid <= s;
        repeat (16) @(posedge mclk);
    endtask : apply
    // Expected command fields from the selections, lowest input winning for 1 and 6, opposing jogs cancel
    function automatic logic [11:0] exp_cmd(logic [15:0] f, logic [3:0] d, logic s);
        logic a1, c1, al, cm, jg, jr, pa, lo, sr, sc, sd;
        logic [2:0] ps;
        int k;
        {a1, c1, al, cm, jg, jr, pa, lo, sr, sc, sd} = '0;
        ps = '0;
        k = 0;
        for (int i = 0; i < 4; i++)
            case (f[4*i+:4])
                4'h1: {a1, al} = a1 ? {a1, al} : {1'b1, d[i]};
                4'h2, 4'hb: jg |= d[i];
                4'hc: jr |= d[i];
                4'h4:
                begin
                    ps[k] = d[i];
                    pa |= d[i];
                    k++;
                end
                4'h5: lo |= d[i];
                4'h6: {c1, cm} = c1 ? {c1, cm} : {1'b1, d[i]};
                4'h8: sr |= d[i];
                4'h9: sc |= d[i];
                4'ha: sd |= d[i];
                default: ;
            endcase
        return {al, (jg | jr) & !(jg & jr) & !s, jr & !jg & !s, pa, ps, lo, cm, sr, sc, sd};
    endfunction : exp_cmd
    initial
    begin
        logic [31:0] r;
        logic        e;
        logic [3:0]  d;
        logic        s;
        int          clr0;
        logic [15:0] cfg[4] = '{16'hb544, 16'hc1b2, 16'ha980, 16'h61d1};
        logic [3:0]  dv[8] = '{4'h1, 4'h0, 4'h1, 4'h3, 4'h1, 4'h0, 4'h1, 4'h5};
        logic        av[8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        logic [1:0]  vc[3] = '{2'h2, 2'h1, 2'h3};
        logic [1:0]  ve[3] = '{2'h2, 2'h2, 2'h3};
        void'($urandom(56));
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        apb(1'b0, dif_pkg::OFS_CTRL, 32'h0, r, e);
        chk(r[4:0], 5'h03);
        apb(1'b0, dif_pkg::OFS_FSEL, 32'h0, r, e);
        chk(r[15:0], 16'hb544);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, dif_pkg::OFS_CTRL, {30'h0, vc[i]}, r, e);
            apb(1'b0, dif_pkg::OFS_CTRL, 32'h0, r, e);
            chk(r[4:0], {3'h0, ve[i]});
            chk(cmd.volt_high, ve[i][0]);
        end
        for (int c = 0; c < 4; c++)
        begin
            start_valid <= 1'b0;
            apb(1'b1, dif_pkg::OFS_FSEL, {16'h0, cfg[c]}, r, e);
            for (int k = 0; k < 4; k++)
            begin
                d = (k == 0) ? 4'hf : 4'($urandom);
                s = 1'($urandom) & (c == 0);
                apply(d, s);
                chk(cmd[14:3], exp_cmd(cfg[c], d, s));
                chk(in_sts, d);
                apb(1'b0, dif_pkg::OFS_STATUS, 32'h0, r, e);
                chk(r[3:0], d);
                chk(r[10], c == 3);
            end
        end
        apply(4'h1, 1'b0);
        apb(1'b1, dif_pkg::OFS_FSEL, 32'h0873, r, e);
        clr0 = n_clr;
        for (int i = 0; i < 8; i++)
        begin
            apply(dv[i], 1'b0);
            chk(cmd.aux_fault, av[i]);
        end
        chk(n_clr - clr0, 32'h2);
        apb(1'b0, dif_pkg::OFS_IRQ_STAT, 32'h0, r, e);
        chk(r[3:0], 4'hb);
        chk(irq, 1'b0);
        apb(1'b1, dif_pkg::OFS_IRQ_EN, 32'h1, r, e);
        repeat (2) @(negedge mclk);
        chk(irq, 1'b1);
        apb(1'b1, dif_pkg::OFS_IRQ_CLR, 32'hf, r, e);
        apb(1'b0, dif_pkg::OFS_IRQ_CLR, 32'h0, r, e);
        chk(r, 32'h0);
        chk(irq, 1'b0);
        apb(1'b0, 8'h1c, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        run <= 1'b0;
        apb(1'b1, dif_pkg::OFS_CTRL, 32'h13, r, e);
        repeat (4) @(posedge mclk);
        chk(ol_count, 16'h0);
        apb(1'b0, dif_pkg::OFS_OL_SAVED, 32'h0, r, e);
        chk(r, 32'h0);
        run <= 1'b1;
        repeat (10) @(posedge mclk);
        run <= 1'b0;
        power_good <= 1'b0;
        repeat (8) @(posedge mclk);
        apb(1'b0, dif_pkg::OFS_OL_SAVED, 32'h0, r, e);
        chk(r[15:0], ol_count);
        run <= 1'b1;
        repeat (5) @(posedge mclk);
        run <= 1'b0;
        power_good <= 1'b1;
        repeat (8) @(posedge mclk);
        chk(ol_count, r[15:0]);
        report_and_stop();
    end
endmodule : tb_top
